// ===== pdc_pkg.sv
// Purpose: Constants, state types and decode helpers of the port device control block
// Assumes: 16-bit register at config offset 0x74; lower bits 9:0 live elsewhere
// Notes:   Widths are fixed; sizes are in bytes
package pdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [11:0] PDC_DEVCTL_OFF  = 12'h074;
    localparam int          PDC_RSV_POS     = 15;
    localparam int          PDC_MAX_READ_REQ_SIZE_LSB    = 12;
    localparam int          PDC_MAX_READ_REQ_SIZE_MSB    = 14;
    localparam int          PDC_NS_POS      = 11;
    localparam int          PDC_AUX_POS     = 10;
    localparam logic [2:0]  PDC_MAX_READ_REQ_SIZE_RST    = 3'h5;
    localparam logic        PDC_NS_RST      = 1'b1;
    localparam logic        PDC_AUX_RST     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Read sizing
    localparam logic [12:0] PDC_MAX_READ_REQ_SIZE_BASE   = 13'h0080;
    localparam logic [12:0] PDC_HUB_MAX_RD  = 13'h0040;
    localparam logic [2:0]  PDC_MAX_READ_REQ_SIZE_TOP    = 3'h5;

    typedef logic [12:0] pdc_len_t;

    // Reserved encodings fall back to the smallest size, the safe side
    function automatic pdc_len_t pdc_max_read_req_size_bytes(input logic [2:0] code);
        if (code > PDC_MAX_READ_REQ_SIZE_TOP) begin
            return PDC_MAX_READ_REQ_SIZE_BASE;
        end
        return pdc_len_t'(PDC_MAX_READ_REQ_SIZE_BASE << code);
    endfunction : pdc_max_read_req_size_bytes

    ////////////////////////////////////////////////////////////////////////////////
    // State of the top module
    typedef struct packed {
        logic [15:0] cfg_rdata;
        logic        cfg_ack;
        logic [2:0]  max_read_req_size;
        logic        ns_permit;
        logic        aux_en;
        logic [2:0]  aux_grant;
        logic        busy;
        logic        ns_req;
        logic [31:0] cur_addr;
        pdc_len_t    remain;
        logic        in_ready;
        logic        out_valid;
        logic [31:0] out_addr;
        pdc_len_t    out_len;
        logic        out_ns;
        logic        rx_valid;
        logic        rx_ns;
    } pdc_state_t;

endpackage : pdc_pkg

// ===== pdc_lim_if.sv
// Purpose: Carries the size field to the limiter and the resulting chunk limit back
// Assumes: Purely combinational path
// Notes:   None
`timescale 1ns/1ps
interface pdc_lim_if;
    logic [2:0]  max_read_req_size;
    logic [12:0] limit;
    modport ctl (output max_read_req_size, input limit);
    modport lim (input max_read_req_size, output limit);
endinterface : pdc_lim_if

// ===== pdc_rd_limit.sv
// Purpose: Turns the read request size field into the largest read the port may issue
// Assumes: Field value is the registered one
// Notes:   Hub ceiling always wins over the field
`timescale 1ns/1ps
module pdc_rd_limit (
    pdc_lim_if.lim lim
);
    import pdc_pkg::*;

    logic [12:0] fld_bytes;

    ////////////////////////////////////////////////////////////////////////////////
    // power-of-two decode
    assign fld_bytes = pdc_max_read_req_size_bytes(lim.max_read_req_size);

    assign lim.limit = (fld_bytes < PDC_HUB_MAX_RD) ? fld_bytes : PDC_HUB_MAX_RD;

endmodule : pdc_rd_limit

// ===== pdc_devctl.sv
// Purpose: Upper device control bits of a root port and the outbound read splitter they steer
// Assumes: rst_b is power-on reset; hot_rst is the ordinary synchronous reset
// Notes:   Sticky aux enable survives hot_rst; received attributes pass unchanged
//
// Overview of operation
// - Read-write three-bit read size field in bits 14:12, reset value 101.
// - Field encodes 128 bytes doubling to 4096 at 101; 110 and 111 reserved.
// - No issued read request is longer than the size the field selects.
// - Outbound reads never exceed 64 bytes whatever the field allows.
// - Bit 11 permits marking no-snoop on originated requests; resets to 1.
// - No-snoop attribute of received packets is never set or changed.
// - Bit 10 is sticky aux power enable, reset 0, permits aux draw.
// - Aux power follows aux current field, independent of wake event enable.
`timescale 1ns/1ps
module pdc_devctl (
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hot_rst,
    // Configuration access
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [1:0]  cfg_be,
    input  wire logic [15:0] cfg_wdata,
    output logic      [15:0] cfg_rdata,
    output logic             cfg_ack,
    // Read requests from the hub core
    input  wire logic        rd_in_valid,
    input  wire logic [31:0] rd_in_addr,
    input  wire pdc_pkg::pdc_len_t rd_in_len,
    input  wire logic        rd_in_ns_req,
    output logic             rd_in_ready,
    // Read requests toward the link
    output logic             rd_out_valid,
    output logic      [31:0] rd_out_addr,
    output pdc_pkg::pdc_len_t rd_out_len,
    output logic             rd_out_ns,
    input  wire logic        rd_out_ready,
    // Received packet attribute path
    input  wire logic        rx_tlp_valid,
    input  wire logic        rx_ns_in,
    output logic             rx_fwd_valid,
    output logic             rx_fwd_ns,
    // Power management
    input  wire logic [2:0]  aux_current,
    output logic      [2:0]  aux_grant
);
    import pdc_pkg::*;

    pdc_state_t s_r;
    pdc_state_t s_nxt;
    pdc_len_t   chunk;
    logic       hit;
    logic       accept;
    logic       issue;

    pdc_lim_if lif ();

    assign lif.max_read_req_size = s_r.max_read_req_size;

    pdc_rd_limit u_lim (
        .lim (lif.lim)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    assign hit    = cfg_req && (cfg_addr == PDC_DEVCTL_OFF);
    assign accept = s_r.in_ready && rd_in_valid;
    assign issue  = s_r.busy && (!s_r.out_valid || rd_out_ready);
    // Limit is re-read per chunk, so a size change applies at the next chunk
    assign chunk  = (s_r.remain > lif.limit) ? lif.limit : s_r.remain;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.cfg_ack = cfg_req;
        if (cfg_req) begin
            s_nxt.cfg_rdata = 16'h0000;
            if (hit) begin
                s_nxt.cfg_rdata[PDC_RSV_POS]               = 1'b0;
                s_nxt.cfg_rdata[PDC_MAX_READ_REQ_SIZE_MSB:PDC_MAX_READ_REQ_SIZE_LSB] = s_r.max_read_req_size;
                s_nxt.cfg_rdata[PDC_NS_POS]                = s_r.ns_permit;
                s_nxt.cfg_rdata[PDC_AUX_POS]               = s_r.aux_en;
            end
        end
        if (hit && cfg_we && cfg_be[1]) begin
            s_nxt.max_read_req_size      = cfg_wdata[PDC_MAX_READ_REQ_SIZE_MSB:PDC_MAX_READ_REQ_SIZE_LSB];
            s_nxt.ns_permit = cfg_wdata[PDC_NS_POS];
            s_nxt.aux_en    = cfg_wdata[PDC_AUX_POS];
        end

        s_nxt.aux_grant = s_r.aux_en ? aux_current : 3'h0;

        s_nxt.rx_valid = rx_tlp_valid;
        s_nxt.rx_ns    = rx_tlp_valid ? rx_ns_in : s_r.rx_ns;

        // Slot frees as the link takes it; a new chunk may refill it at once
        if (s_r.out_valid && rd_out_ready) begin
            s_nxt.out_valid = 1'b0;
        end
        if (issue) begin
            s_nxt.out_valid = 1'b1;
            s_nxt.out_addr  = s_r.cur_addr;
            s_nxt.out_len   = chunk;
            s_nxt.out_ns    = s_r.ns_req && s_r.ns_permit;
            s_nxt.cur_addr  = s_r.cur_addr + 32'(chunk);
            s_nxt.remain    = s_r.remain - chunk;
            if (s_r.remain == chunk) begin
                s_nxt.busy     = 1'b0;
                s_nxt.in_ready = 1'b1;
            end
        end
        // Zero-length requests are dropped, never split
        if (accept && (rd_in_len != 13'h0000)) begin
            s_nxt.busy     = 1'b1;
            s_nxt.in_ready = 1'b0;
            s_nxt.cur_addr = rd_in_addr;
            s_nxt.remain   = rd_in_len;
            s_nxt.ns_req   = rd_in_ns_req;
        end

        // Hot reset last, so it beats any write in the same cycle
        if (hot_rst) begin
            s_nxt           = '0;
            s_nxt.max_read_req_size      = PDC_MAX_READ_REQ_SIZE_RST;
            s_nxt.ns_permit = PDC_NS_RST;
            s_nxt.aux_en    = s_r.aux_en;
            s_nxt.in_ready  = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Power-on reset is the only one that clears the sticky aux enable
            s_r           <= '0;
            s_r.max_read_req_size      <= PDC_MAX_READ_REQ_SIZE_RST;
            s_r.ns_permit <= PDC_NS_RST;
            s_r.aux_en    <= PDC_AUX_RST;
            s_r.in_ready  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign cfg_rdata    = s_r.cfg_rdata;
    assign cfg_ack      = s_r.cfg_ack;
    assign rd_in_ready  = s_r.in_ready;
    assign rd_out_valid = s_r.out_valid;
    assign rd_out_addr  = s_r.out_addr;
    assign rd_out_len   = s_r.out_len;
    assign rd_out_ns    = s_r.out_ns;
    assign rx_fwd_valid = s_r.rx_valid;
    assign rx_fwd_ns    = s_r.rx_ns;
    assign aux_grant    = s_r.aux_grant;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_size_write;
        hit && cfg_we && cfg_be[1] && !hot_rst;
    endsequence

    a_size_field_wr: assert property (s_size_write |=> s_r.max_read_req_size == $past(cfg_wdata[14:12]))
        else $error("size field did not take written value");
    a_size_decode: assert property (s_r.max_read_req_size == 3'h3 |-> pdc_max_read_req_size_bytes(s_r.max_read_req_size) == 13'h0400)
        else $error("size decode wrong");
    a_out_field_cap: assert property (rd_out_valid |-> rd_out_len <= pdc_max_read_req_size_bytes(s_r.max_read_req_size))
        else $error("read longer than size field");
    a_out_hub_cap: assert property (rd_out_valid |-> rd_out_len <= 13'h0040 && rd_out_len != 13'h0000)
        else $error("read longer than hub ceiling");
    a_ns_mark_gate: assert property (issue && !hot_rst |=> rd_out_ns == $past(s_r.ns_req && s_r.ns_permit))
        else $error("no-snoop marked without permission");
    a_rx_ns_keep: assert property (rx_tlp_valid && !hot_rst |=> rx_fwd_valid && rx_fwd_ns == $past(rx_ns_in))
        else $error("received no-snoop attribute altered");
    a_aux_sticky: assert property (hot_rst |=> s_r.aux_en == $past(s_r.aux_en) ##1 (aux_grant == 3'h0 || $past(s_r.aux_en)))
        else $error("aux enable lost on hot reset");
    a_aux_grant_map: assert property (!hot_rst |=> aux_grant == ($past(s_r.aux_en) ? $past(aux_current) : 3'h0))
        else $error("aux grant does not follow aux current");
    a_rsv_bit_zero: assert property (cfg_ack |-> cfg_rdata[15] == 1'b0)
        else $error("reserved bit read as one");

    // A stalled sub-request must stand still until the link takes it
    sequence s_out_stall;
        rd_out_valid && !rd_out_ready && !hot_rst;
    endsequence

    sequence s_out_same;
        rd_out_valid && $stable(rd_out_addr) && $stable(rd_out_len) && $stable(rd_out_ns);
    endsequence

    sequence s_take;
        rd_in_valid && rd_in_ready && (rd_in_len != 13'h0000) && !hot_rst;
    endsequence

    a_out_req_hold: assert property (s_out_stall |=> s_out_same)
        else $error("held read request changed before acceptance");
    a_take_ready_low: assert property (s_take |=> !rd_in_ready)
        else $error("core request accepted while splitting");
    a_cfg_ack_next: assert property (cfg_req && !hot_rst |=> cfg_ack)
        else $error("config access not acknowledged");
    a_unmapped_zero: assert property (cfg_req && !hit |=> cfg_rdata == 16'h0000)
        else $error("unmapped offset returned data");
    a_hot_rst_fields: assert property (hot_rst |=> s_r.max_read_req_size == PDC_MAX_READ_REQ_SIZE_RST && s_r.ns_permit == PDC_NS_RST)
        else $error("fields not at reset values after hot reset");
    a_rx_ns_idle: assert property (!rx_tlp_valid && !hot_rst |=> !rx_fwd_valid && $stable(rx_fwd_ns))
        else $error("received attribute path moved without a packet");

endmodule : pdc_devctl

// ===== pdc_link_model.sv
// Purpose: Link-side acceptor of outbound read sub-requests
// Assumes: Accepts on rd_out_ready at a rising edge
// Notes:   Slow mode stalls every other cycle to stress the hold of requests
`timescale 1ns/1ps
module pdc_link_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Pacing
    input  wire logic slow,
    output logic      ready
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready <= 1'b0;
        end else begin
            ready <= slow ? ~ready : 1'b1;
        end
    end
endmodule : pdc_link_model

// ===== pdc_devctl_tb.sv
// Purpose: Self-checking bench of the port device control block
// Assumes: Inputs change on the falling edge
// Notes:   Register rows first, then refused writes, aux and reset, split and rx cases
`timescale 1ns/1ps
module pdc_devctl_tb;
    import pdc_pkg::*;
    logic        clk = 0, rst_b = 0, hot_rst = 0, req = 0, we = 0, slow = 0;
    logic [11:0] addr = 12'h074;
    logic [1:0]  be = 2'h3;
    logic [15:0] wd = 0, rd, rdata;
    logic        ack, in_v = 0, in_ns = 0, in_rdy, o_v, o_ns, o_rdy, rx_v = 0, rx_ns = 0, f_v, f_ns;
    logic [31:0] in_a = 0, o_a;
    pdc_len_t    in_l = 0, o_l;
    logic [2:0]  aux_cur = 3'h5, grant;
    int          miscompares = 0, cmp_count = 0;
    logic [15:0] rows [5][2] = '{'{16'hffff, 16'h7c00}, '{16'h0000, 16'h0000},
                                 '{16'h6400, 16'h6400}, '{16'h0c00, 16'h0c00}, '{16'h5800, 16'h5800}};
    always #4 clk = ~clk;
    pdc_devctl u_pdc_devctl (.clk(clk), .rst_b(rst_b), .hot_rst(hot_rst), .cfg_req(req), .cfg_we(we),
        .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdata), .cfg_ack(ack),
        .rd_in_valid(in_v), .rd_in_addr(in_a), .rd_in_len(in_l), .rd_in_ns_req(in_ns), .rd_in_ready(in_rdy),
        .rd_out_valid(o_v), .rd_out_addr(o_a), .rd_out_len(o_l), .rd_out_ns(o_ns), .rd_out_ready(o_rdy),
        .rx_tlp_valid(rx_v), .rx_ns_in(rx_ns), .rx_fwd_valid(f_v), .rx_fwd_ns(f_ns),
        .aux_current(aux_cur), .aux_grant(grant));
    pdc_link_model u_pdc_link_model (.clk(clk), .rst_b(rst_b), .slow(slow), .ready(o_rdy));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One access; ack rises on the taking edge and is checked half a cycle later
    task automatic cfg(input logic w, input logic [11:0] a, input logic [1:0] b, input logic [15:0] d);
        @(negedge clk);
        req = 1; we = w; addr = a; be = b; wd = d;
        @(negedge clk);
        req = 0;
        chk(ack, 1);
        rd = rdata;
    endtask : cfg
    task automatic split(input logic [15:0] c, input pdc_len_t len, input logic ns_exp);
        pdc_len_t rem;
        logic [31:0] a;
        cfg(1, 12'h074, 2'h3, c);
        rem = len;
        a = 32'h0000_1000;
        @(negedge clk);
        chk(in_rdy, 1);
        in_v = 1; in_a = a; in_l = len; in_ns = 1;
        @(negedge clk);
        in_v = 0;
        chk(in_rdy, 0);
        for (int n = 0; n < 300 && rem != 0; n++) begin
            @(negedge clk);
            if (o_v && o_rdy) begin
                chk(o_l, (rem > 64) ? 64 : rem);
                chk(o_a, a);
                chk(o_ns, ns_exp);
                a = a + 64;
                rem = (rem > 64) ? rem - 64 : 0;
            end
        end
        chk(rem, 0);
        if (rem != 0) begin
            wrap_up();
        end
        $display("test split len %0d done", len);
    endtask : split
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_b = 1;
        cfg(0, 12'h074, 2'h3, 0);
        chk(rd, 16'h5800);
        foreach (rows[i]) begin
            cfg(1, 12'h074, 2'h3, rows[i][0]);
            cfg(0, 12'h074, 2'h3, 0);
            chk(rd, rows[i][1]);
        end
        $display("test rows done");
        // Writes with the upper byte disabled and to unmapped offsets are dropped
        cfg(1, 12'h074, 2'h1, 16'h0000);
        cfg(1, 12'h070, 2'h3, 16'h0000);
        cfg(0, 12'h070, 2'h3, 0);
        chk(rd, 0);
        cfg(0, 12'h074, 2'h3, 0);
        chk(rd, 16'h5800);
        $display("test refused done");
        cfg(1, 12'h074, 2'h3, 16'h0400);
        repeat (2) @(negedge clk);
        chk(grant, 3'h5);
        aux_cur = 3'h2;
        repeat (2) @(negedge clk);
        chk(grant, 3'h2);
        hot_rst = 1;
        @(negedge clk);
        hot_rst = 0;
        cfg(0, 12'h074, 2'h3, 0);
        chk(rd, 16'h5c00);
        rst_b = 0;
        repeat (2) @(negedge clk);
        rst_b = 1;
        cfg(0, 12'h074, 2'h3, 0);
        chk(rd, 16'h5800);
        chk(grant, 0);
        $display("test sticky done");
        split(16'h5800, 200, 1);
        slow = 1;
        split(16'h0000, 130, 0);
        split(16'h0800, 64, 1);
        // Received attribute passes unchanged, permit set and then cleared
        for (int v = 0; v < 4; v++) begin
            if (v == 2) begin
                cfg(1, 12'h074, 2'h3, 16'h0000);
            end
            @(negedge clk);
            rx_v = 1; rx_ns = v[0];
            @(negedge clk);
            rx_v = 0;
            chk(f_v, 1);
            chk(f_ns, v[0]);
        end
        $display("test rx done");
        wrap_up();
    end
endmodule : pdc_devctl_tb
